// ===== include/psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_CTRL_OFS 12'h000
`define PSC_STATUS_OFS 12'h004
`define PSC_DOMSRC_OFS 12'h008
`define PSC_WAKE_EN_OFS 12'h00C
`define PSC_WAKE_SRC_OFS 12'h010
`define PSC_CTRL_CMD_LSB 0
`define PSC_CTRL_PS2SRC_BIT 4
`define PSC_CTRL_DONE_SLEEP_BIT 5
`define PSC_CMD_NONE 3'h0
`define PSC_CMD_GO_FULL 3'h1
`define PSC_CMD_GO_REDUCED 3'h2
`define PSC_CMD_GO_LOWV 3'h3
`define PSC_CMD_SLEEP 3'h4
`define PSC_CMD_SHUTDOWN 3'h5
`define PSC_CMD_GATED 3'h6
`define PSC_DOMSRC_RST 14'h0000
`define PSC_WAKE_EN_RST 16'h0000
`define PSC_SRC_MAIN 2'h0
`define PSC_SRC_SCC 2'h1
`define PSC_SRC_RET 2'h2
`define PSC_SRC_ALWAYS_ON_DOM 6
`define PSC_NDOM 7
`define PSC_WAKE_TIMER_BIT 0
`define PSC_MHZ_FULL 8'hB4
`define PSC_MHZ_REDUCED 8'h5A
`define PSC_MHZ_LOWV_RET 8'h14
`define PSC_MHZ_LOWV_SCC 8'h20
`define PSC_MEM_OFF 2'h0
`define PSC_MEM_RETAIN 2'h1
`define PSC_MEM_ACTIVE 2'h2
`endif

// ===== include/psc_pkg.sv
package psc_pkg;
  typedef enum logic [10:0] {
    PSC_FULL = 11'h001,
    PSC_REDUCED = 11'h002,
    PSC_LOWV = 11'h004,
    PSC_GATED = 11'h008,
    PSC_SHUTDOWN = 11'h010,
    PSC_FULL_STBY = 11'h020,
    PSC_RED_STBY = 11'h040,
    PSC_LOWV_STBY = 11'h080,
    PSC_FULL_SLEEP = 11'h100,
    PSC_RED_SLEEP = 11'h200,
    PSC_LOWV_SLEEP = 11'h400
  } psc_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } psc_wr_s;

  typedef struct packed {
    logic [7:0] cpu_mhz_limit;
    logic fast_clock_en;
    logic cpu_clock_en;
    logic cpu_power_en;
    logic hp_periph_en;
    logic lp_periph_en;
    logic ao_periph_en;
    logic general_pins_en;
    logic low_power_pins_en;
    logic battery_pins_en;
    logic [1:0] main_mem;
    logic [1:0] lp_mem;
    logic main_reg_on;
    logic [1:0] main_reg_volt;
    logic periph_cfg_reset;
  } psc_pwr_s;

  typedef struct packed {
    psc_state_e st;
    psc_state_e ret;
    logic [13:0] domsrc;
    logic ps2src;
    logic done_sleep;
    logic [15:0] wake_en;
    logic [15:0] wake_src;
    logic cfg_rst;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    psc_wr_s wr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    psc_pwr_s pwr;
  } psc_st_s;
endpackage : psc_pkg

// ===== sim/power_state_controller_bench.sv
`timescale 1ns/1ps
`include "psc_map.svh"
module power_state_controller_bench;
  import psc_pkg::*;
  logic aclk, aresetn;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd_q;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp, rr_q;
  logic wfi_req, wfi_exec;
  logic [15:0] wake_req, tbl_req, wake_irq, table_irq;
  logic [4:0] bkp_addr;
  logic bkp_we;
  logic [7:0] bkp_wdata, bkp_rdata;
  psc_pwr_s pwr;
  logic [13:0] dom_src;
  psc_state_e state;
  int n_mismatch, tests_run;
  int cyc = 0;

  psc_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .wfi_exec(wfi_exec), .wake_irq(wake_irq), .table_irq(table_irq), .periph_done(1'b0),
    .bkp_addr(bkp_addr), .bkp_we(bkp_we), .bkp_wdata(bkp_wdata), .bkp_rdata(bkp_rdata),
    .pwr(pwr), .dom_src(dom_src), .state(state));
  psc_src_model u_src (.aclk(aclk), .wfi_req(wfi_req), .wake_req(wake_req), .tbl_req(tbl_req),
    .wfi_exec(wfi_exec), .wake_irq(wake_irq), .table_irq(table_irq));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // Address and data are released independently, each at the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && s_awready === 1'b1) begin
        ga = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!gw && s_wready === 1'b1) begin
        gw = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    while (s_bvalid !== 1'b1) @(posedge aclk);
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    rd_q = s_rdata;
    rr_q = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic wst(input psc_state_e e);
    int n;
    n = 0;
    while (state !== e && n < 30) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(state), 32'(e));
  endtask : wst

  // Wake lines are held until the target state shows, then the sticky sources are cleared.
  task automatic wake(input logic [15:0] w, input logic [15:0] t, input psc_state_e e);
    wake_req <= w;
    tbl_req <= t;
    wst(e);
    wake_req <= 16'h0000;
    tbl_req <= 16'h0000;
    wr(`PSC_WAKE_SRC_OFS, 32'h0000FFFF);
  endtask : wake

  task automatic t_reset;
    chk(32'(state), 32'(PSC_FULL));
    chk({pwr.cpu_mhz_limit, pwr.fast_clock_en}, {`PSC_MHZ_FULL, 1'b1});
    chk({pwr.general_pins_en, pwr.low_power_pins_en, pwr.battery_pins_en, pwr.hp_periph_en, pwr.main_mem},
      {4'hF, `PSC_MEM_ACTIVE});
    wr(`PSC_DOMSRC_OFS, 32'h00000000);
    idle(2);
    chk(dom_src[13:12], `PSC_SRC_SCC);
    rd(`PSC_DOMSRC_OFS);
    chk(rd_q[11:0], 12'h000);
    rd(12'h020);
    chk(rr_q, 2'h2);
    tbl_req <= 16'hFFFF;
    wake_req <= 16'hFFFF;
    idle(5);
    chk(32'(state), 32'(PSC_FULL));
    tbl_req <= 16'h0000;
    wake_req <= 16'h0000;
    idle(2);
  endtask : t_reset

  task automatic t_standby;
    wr(`PSC_CTRL_OFS, 32'(`PSC_CMD_GO_REDUCED));
    wst(PSC_REDUCED);
    chk(pwr.cpu_mhz_limit, `PSC_MHZ_REDUCED);
    wr(`PSC_WAKE_EN_OFS, 32'h00000001);
    wfi_req <= 1'b1;
    idle(1);
    wfi_req <= 1'b0;
    wst(PSC_RED_STBY);
    chk({pwr.cpu_clock_en, pwr.cpu_power_en}, 2'b01);
    wake_req <= 16'h0001;
    idle(5);
    chk(32'(state), 32'(PSC_RED_STBY));
    wake(16'h0001, 16'h8000, PSC_REDUCED);
  endtask : t_standby

  task automatic t_sleep;
    wr(`PSC_CTRL_OFS, 32'(`PSC_CMD_GO_LOWV));
    wst(PSC_LOWV);
    chk(pwr.cpu_mhz_limit, `PSC_MHZ_LOWV_RET);
    chk({pwr.general_pins_en, pwr.hp_periph_en, pwr.lp_periph_en, pwr.ao_periph_en, pwr.low_power_pins_en,
      pwr.battery_pins_en}, 6'h0F);
    wr(`PSC_CTRL_OFS, 32'(`PSC_CMD_SLEEP));
    wst(PSC_LOWV_SLEEP);
    idle(2);
    chk(pwr.main_reg_on, 1'b0);
    chk({pwr.lp_periph_en, pwr.ao_periph_en, pwr.low_power_pins_en, pwr.battery_pins_en}, 4'h5);
    wake(16'h0001, 16'h0000, PSC_LOWV);
  endtask : t_sleep

  task automatic t_gated;
    wr(`PSC_CTRL_OFS, 32'h00000016);
    wst(PSC_GATED);
    chk({pwr.main_mem, pwr.lp_mem, pwr.cpu_power_en}, {`PSC_MEM_RETAIN, `PSC_MEM_ACTIVE, 1'b0});
    wake(16'h0001, 16'h0000, PSC_LOWV);
    chk(pwr.cpu_mhz_limit, `PSC_MHZ_LOWV_SCC);
    // Gated entry with exit to sleep; a one-cycle wake pulse so the sleep state is not left at once.
    wr(`PSC_CTRL_OFS, 32'h00000036);
    wst(PSC_GATED);
    wake_req <= 16'h0001;
    idle(1);
    wake_req <= 16'h0000;
    wst(PSC_LOWV_SLEEP);
    wr(`PSC_WAKE_SRC_OFS, 32'h0000FFFF);
    wake(16'h0001, 16'h0000, PSC_LOWV);
    wr(`PSC_CTRL_OFS, 32'(`PSC_CMD_GO_FULL));
    wst(PSC_FULL);
    wr(`PSC_CTRL_OFS, 32'(`PSC_CMD_GATED));
    idle(5);
    chk(32'(state), 32'(PSC_FULL));
  endtask : t_gated

  task automatic t_shutdown;
    bkp_addr <= 5'h1F;
    bkp_wdata <= 8'hA5;
    bkp_we <= 1'b1;
    idle(1);
    bkp_we <= 1'b0;
    wr(`PSC_CTRL_OFS, 32'(`PSC_CMD_SHUTDOWN));
    wst(PSC_SHUTDOWN);
    chk({pwr.main_mem, pwr.lp_mem, pwr.battery_pins_en, pwr.cpu_power_en}, 6'h02);
    wake_req <= 16'h0002;
    idle(5);
    chk(32'(state), 32'(PSC_SHUTDOWN));
    wake(16'h0001, 16'h0000, PSC_FULL);
    idle(2);
    chk(bkp_rdata, 8'hA5);
  endtask : t_shutdown

  initial begin
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {wfi_req, wake_req, tbl_req, bkp_addr, bkp_we, bkp_wdata} = '0;
    n_mismatch = 0;
    tests_run = 0;
    aresetn = 1'b0;
    idle(16);
    aresetn <= 1'b1;
    idle(1);
    t_reset();
    t_standby();
    t_sleep();
    t_gated();
    t_shutdown();
    results();
  end
endmodule : power_state_controller_bench

// ===== sim/psc_src_model.sv
`timescale 1ns/1ps
module psc_src_model (
  // Clock
  input wire logic aclk,
  // Requests from the bench
  input wire logic wfi_req,
  input wire logic [15:0] wake_req,
  input wire logic [15:0] tbl_req,
  // Event lines toward the controller
  output logic wfi_exec,
  output logic [15:0] wake_irq,
  output logic [15:0] table_irq
);
  logic wfi_prev;
  // The instruction is a single pulse, so a held request cannot re-enter standby right after a wake.
  always @(posedge aclk) begin
    wfi_prev <= wfi_req;
    wfi_exec <= wfi_req & ~wfi_prev;
    wake_irq <= wake_req;
    table_irq <= tbl_req;
  end
endmodule : psc_src_model

// ===== src/psc_ctrl.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "psc_map.svh"
// What this block does
// - Reset lands in full active state.
// - Only software moves active into standby/sleep.
// - Only enabled wakeup interrupts leave low-power states, except table interrupts in full/reduced standby.
// - Wake returns to the entering active state; shutdown wakes to full state.
// - Main regulator sourced domains lose power in sleep.
// - Always-on domain only from switched-cap converter.
// - Full state: main regulator 1.15V, 180MHz, fast clock.
// - Full state: all pins, peripherals, memory usable.
// - Reduced state: 1.05V, clock limited to 90MHz.
// - Low-voltage: bus clock, 20 or 32MHz limit.
// - Low-voltage keeps low-power, always-on, analog, pins.
// - Gated state only from low-voltage, by software.
// - Gated-state interrupts wake or enter sleep.
// - Gated state: main memory retained, low memory active.
// - Wait-for-interrupt enters standby, clock gated only.
// - Full/reduced standby wake on any table interrupt.
// - Sleep keeps always-on, analog, battery pins, memory.
// - Sleep exit resets peripheral configuration.
// - Shutdown: power-gated, memory lost, battery pins kept.
// - Backup registers retained in sleep and shutdown.
// - Deep-sleep timer wakes sleep, shutdown, never standby.
module psc_ctrl
  import psc_pkg::*;
#(
  parameter int BACKUP_BYTES = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Processor and wakeup events
  input wire logic wfi_exec,
  input wire logic [15:0] wake_irq,
  input wire logic [15:0] table_irq,
  input wire logic periph_done,
  // Backup register array port
  input wire logic [4:0] bkp_addr,
  input wire logic bkp_we,
  input wire logic [7:0] bkp_wdata,
  output logic [7:0] bkp_rdata,
  // Power controls
  output psc_pwr_s pwr,
  output logic [13:0] dom_src,
  output psc_state_e state
);
  psc_st_s q, d;
  logic [7:0] bkp_mem [BACKUP_BYTES];
  logic [7:0] bkp_q;

  function automatic logic is_active(psc_state_e s);
    is_active = (s == PSC_FULL) || (s == PSC_REDUCED) || (s == PSC_LOWV);
  endfunction : is_active

  function automatic psc_pwr_s pwr_of(psc_state_e s, logic ps2src, logic rst);
    psc_pwr_s p;
    p = '0;
    p.ao_periph_en = 1'b1;
    p.battery_pins_en = 1'b1;
    p.periph_cfg_reset = rst;
    p.main_reg_volt = 2'h0;
    case (s)
      PSC_FULL, PSC_FULL_STBY, PSC_REDUCED, PSC_RED_STBY: begin
        p.cpu_mhz_limit = (s == PSC_FULL || s == PSC_FULL_STBY) ? `PSC_MHZ_FULL : `PSC_MHZ_REDUCED;
        p.main_reg_volt = (s == PSC_FULL || s == PSC_FULL_STBY) ? 2'h2 : 2'h1;
        p.fast_clock_en = 1'b1;
        p.cpu_clock_en = (s == PSC_FULL || s == PSC_REDUCED);
        p.cpu_power_en = 1'b1;
        p.hp_periph_en = 1'b1;
        p.lp_periph_en = 1'b1;
        p.general_pins_en = 1'b1;
        p.low_power_pins_en = 1'b1;
        p.main_mem = `PSC_MEM_ACTIVE;
        p.lp_mem = `PSC_MEM_ACTIVE;
        p.main_reg_on = 1'b1;
      end
      PSC_LOWV, PSC_LOWV_STBY: begin
        p.cpu_mhz_limit = ps2src ? `PSC_MHZ_LOWV_SCC : `PSC_MHZ_LOWV_RET;
        p.cpu_clock_en = (s == PSC_LOWV);
        p.cpu_power_en = 1'b1;
        p.lp_periph_en = 1'b1;
        p.low_power_pins_en = 1'b1;
        p.main_mem = `PSC_MEM_ACTIVE;
        p.lp_mem = `PSC_MEM_ACTIVE;
        p.main_reg_on = 1'b1;
      end
      PSC_GATED: begin
        p.lp_periph_en = 1'b1;
        p.low_power_pins_en = 1'b1;
        p.main_mem = `PSC_MEM_RETAIN;
        p.lp_mem = `PSC_MEM_ACTIVE;
        p.main_reg_on = 1'b1;
      end
      PSC_FULL_SLEEP, PSC_RED_SLEEP, PSC_LOWV_SLEEP: begin
        p.main_mem = `PSC_MEM_RETAIN;
        p.lp_mem = `PSC_MEM_RETAIN;
      end
      default: begin
        p.main_mem = `PSC_MEM_OFF;
        p.lp_mem = `PSC_MEM_OFF;
      end
    endcase
    pwr_of = p;
  endfunction : pwr_of

  logic [15:0] wake_hit;
  logic in_sleep;
  logic wr_fire;
  logic [2:0] cmd;

  always_comb begin
    d = q;
    d.cfg_rst = 1'b0;
    in_sleep = (q.st == PSC_FULL_SLEEP) || (q.st == PSC_RED_SLEEP) || (q.st == PSC_LOWV_SLEEP);
    wake_hit = wake_irq & q.wake_en;
    if (q.st == PSC_FULL_STBY || q.st == PSC_RED_STBY || q.st == PSC_LOWV_STBY) begin
      wake_hit[`PSC_WAKE_TIMER_BIT] = 1'b0;
    end
    cmd = 3'h0;
    // Write channel: address and data may arrive in either order.
    d.awready = 1'b0;
    d.wready = 1'b0;
    if (s_awvalid && !q.aw_got && !q.awready && !q.bvalid) begin
      d.awready = 1'b1;
    end
    if (s_wvalid && !q.w_got && !q.wready && !q.bvalid) begin
      d.wready = 1'b1;
    end
    if (q.awready) begin
      d.aw_got = 1'b1;
      d.wr.addr = {20'h00000, s_awaddr};
    end
    if (q.wready) begin
      d.w_got = 1'b1;
      d.wr.data = s_wdata;
      d.wr.strb = s_wstrb;
    end
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'h0;
      case (q.wr.addr[11:0])
        `PSC_CTRL_OFS: begin
          if (q.wr.strb[0]) begin
            cmd = q.wr.data[`PSC_CTRL_CMD_LSB +: 3];
            d.ps2src = q.wr.data[`PSC_CTRL_PS2SRC_BIT];
            d.done_sleep = q.wr.data[`PSC_CTRL_DONE_SLEEP_BIT];
          end
        end
        `PSC_DOMSRC_OFS: begin
          if (q.wr.strb[0]) d.domsrc[7:0] = q.wr.data[7:0];
          if (q.wr.strb[1]) d.domsrc[13:8] = q.wr.data[13:8];
          d.domsrc[2*`PSC_SRC_ALWAYS_ON_DOM +: 2] = `PSC_SRC_SCC;
        end
        `PSC_WAKE_EN_OFS: begin
          if (q.wr.strb[0]) d.wake_en[7:0] = q.wr.data[7:0];
          if (q.wr.strb[1]) d.wake_en[15:8] = q.wr.data[15:8];
        end
        `PSC_WAKE_SRC_OFS: begin
          d.wake_src = q.wake_src & ~q.wr.data[15:0];
        end
        `PSC_STATUS_OFS: d.bresp = 2'h0;
        default: d.bresp = 2'h2;
      endcase
    end
    if (q.bvalid && s_bready) begin
      d.bvalid = 1'b0;
    end
    // Read channel.
    if (q.rvalid && s_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = 2'h0;
      case (s_araddr)
        `PSC_CTRL_OFS: d.rdata = {26'h0000000, q.done_sleep, q.ps2src, 4'h0};
        `PSC_STATUS_OFS: d.rdata = {10'h000, q.ret, q.st};
        `PSC_DOMSRC_OFS: d.rdata = {18'h00000, q.domsrc};
        `PSC_WAKE_EN_OFS: d.rdata = {16'h0000, q.wake_en};
        `PSC_WAKE_SRC_OFS: d.rdata = {16'h0000, q.wake_src};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = 2'h2;
        end
      endcase
    end
    // State sequencing; only software commands and the wait instruction leave active states.
    case (q.st)
      PSC_FULL, PSC_REDUCED, PSC_LOWV: begin
        if (wfi_exec) begin
          d.ret = q.st;
          d.st = (q.st == PSC_FULL) ? PSC_FULL_STBY : (q.st == PSC_REDUCED) ? PSC_RED_STBY : PSC_LOWV_STBY;
        end else if (cmd == `PSC_CMD_SLEEP) begin
          d.ret = q.st;
          d.st = (q.st == PSC_FULL) ? PSC_FULL_SLEEP : (q.st == PSC_REDUCED) ? PSC_RED_SLEEP : PSC_LOWV_SLEEP;
        end else if (cmd == `PSC_CMD_SHUTDOWN) begin
          d.st = PSC_SHUTDOWN;
        end else if (cmd == `PSC_CMD_GATED && q.st == PSC_LOWV) begin
          d.ret = q.st;
          d.st = PSC_GATED;
        end else if (cmd == `PSC_CMD_GO_FULL) begin
          d.st = PSC_FULL;
        end else if (cmd == `PSC_CMD_GO_REDUCED) begin
          d.st = PSC_REDUCED;
        end else if (cmd == `PSC_CMD_GO_LOWV) begin
          d.st = PSC_LOWV;
        end
      end
      PSC_FULL_STBY, PSC_RED_STBY: begin
        if (|table_irq || |wake_hit) begin
          d.st = q.ret;
        end
      end
      PSC_LOWV_STBY: begin
        if (|wake_hit) d.st = q.ret;
      end
      PSC_GATED: begin
        if (|wake_hit) begin
          d.st = q.done_sleep ? PSC_LOWV_SLEEP : PSC_LOWV;
        end
      end
      PSC_FULL_SLEEP, PSC_RED_SLEEP, PSC_LOWV_SLEEP: begin
        if (|wake_hit) begin
          d.st = q.ret;
          d.cfg_rst = 1'b1;
        end
      end
      PSC_SHUTDOWN: begin
        if (|wake_hit) begin
          d.st = PSC_FULL;
          d.cfg_rst = 1'b1;
        end
      end
      default: d.st = PSC_FULL;
    endcase
    // Set wins over a software clear of the latched wake sources.
    d.wake_src = d.wake_src | wake_hit;
    d.pwr = pwr_of(d.st, d.ps2src, d.cfg_rst);
    if (in_sleep && (d.st == q.st)) begin
      d.pwr.main_reg_on = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= PSC_FULL;
      q.ret <= PSC_FULL;
      q.domsrc <= `PSC_DOMSRC_RST | (14'(`PSC_SRC_SCC) << (2*`PSC_SRC_ALWAYS_ON_DOM));
      q.wake_en <= `PSC_WAKE_EN_RST;
      q.pwr <= pwr_of(PSC_FULL, 1'b0, 1'b0);
    end else begin
      q <= d;
    end
  end

  // Backup bytes sit on the always-on supply and have no reset, so they survive every state.
  always_ff @(posedge aclk) begin
    if (bkp_we) begin
      bkp_mem[bkp_addr] <= bkp_wdata;
    end
    bkp_q <= bkp_mem[bkp_addr];
  end

  assign bkp_rdata = bkp_q;
  assign s_awready = q.awready;
  assign s_wready = q.wready;
  assign s_bvalid = q.bvalid;
  assign s_bresp = q.bresp;
  assign s_arready = s_arvalid && !q.rvalid;
  assign s_rvalid = q.rvalid;
  assign s_rdata = q.rdata;
  assign s_rresp = q.rresp;
  assign pwr = q.pwr;
  assign dom_src = q.domsrc;
  assign state = q.st;

  reset_full_a: assert property (@(posedge aclk) !aresetn |=> state == PSC_FULL) else $error("not full after reset");
  no_hw_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_active(state) && !wr_fire && !wfi_exec) |=> is_active(state) || state == PSC_GATED)
    else $error("hardware left active state");
  wake_enabled_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == PSC_LOWV_STBY && !(|(wake_irq & q.wake_en))) |=> state == PSC_LOWV_STBY)
    else $error("woke without enabled source");
  wake_return_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(in_sleep) && $changed(state)) |-> state == $past(q.ret)) else $error("wrong return state");
  sleep_reg_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_sleep && $stable(state)) |-> !pwr.main_reg_on) else $error("main regulator on in sleep");
  ao_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dom_src[2*`PSC_SRC_ALWAYS_ON_DOM +: 2] == `PSC_SRC_SCC) else $error("always-on source wrong");
  full_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_FULL |-> pwr.cpu_mhz_limit == `PSC_MHZ_FULL && pwr.fast_clock_en) else $error("full clock");
  full_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_FULL |-> pwr.general_pins_en && pwr.hp_periph_en && pwr.main_mem == `PSC_MEM_ACTIVE)
    else $error("full resources");
  red_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_REDUCED |-> pwr.cpu_mhz_limit == `PSC_MHZ_REDUCED) else $error("reduced clock");
  lowv_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_LOWV |-> pwr.cpu_mhz_limit == (q.ps2src ? `PSC_MHZ_LOWV_SCC : `PSC_MHZ_LOWV_RET))
    else $error("low-voltage clock");
  lowv_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_LOWV |-> !pwr.hp_periph_en && !pwr.general_pins_en && pwr.low_power_pins_en)
    else $error("low-voltage resources");
  gated_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == PSC_GATED && $changed(state)) |-> $past(state) == PSC_LOWV) else $error("bad gated entry");
  gated_mem_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_GATED |-> !pwr.cpu_power_en && pwr.main_mem == `PSC_MEM_RETAIN) else $error("gated mem");
  stby_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_FULL_STBY |-> !pwr.cpu_clock_en && pwr.cpu_power_en) else $error("standby gating");
  sleep_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(in_sleep) && $changed(state)) |-> pwr.periph_cfg_reset) else $error("no cfg reset");
  shut_mem_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_SHUTDOWN |-> pwr.main_mem == `PSC_MEM_OFF && pwr.battery_pins_en) else $error("shutdown");

  // Wakeup paths: each low-power state must leave by its own sources; standby returns where it came from, shutdown lands in full.
  stby_table_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state == PSC_FULL_STBY || state == PSC_RED_STBY) && |table_irq) |=> state == $past(q.ret))
    else $error("table interrupt did not wake standby");
  stby_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == PSC_LOWV_STBY && (wake_irq & q.wake_en) == 16'h0001) |=> state == PSC_LOWV_STBY)
    else $error("timer woke standby");
  sleep_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_sleep && wake_irq[`PSC_WAKE_TIMER_BIT] && q.wake_en[`PSC_WAKE_TIMER_BIT]) |=> is_active(state))
    else $error("timer did not wake sleep");
  shut_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == PSC_SHUTDOWN && |(wake_irq & q.wake_en)) |=> state == PSC_FULL && pwr.periph_cfg_reset)
    else $error("shutdown wake wrong");
  gated_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == PSC_GATED && |(wake_irq & q.wake_en)) |=> state == ($past(q.done_sleep) ? PSC_LOWV_SLEEP : PSC_LOWV))
    else $error("gated wake wrong");
  stby_ret_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_active(state) && wfi_exec) |=> !is_active(state) && q.ret == $past(state))
    else $error("return state not recorded");

  // Supply and resource profiles per state.
  full_volt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_FULL |-> pwr.main_reg_volt == 2'h2 && pwr.main_reg_on)
    else $error("full voltage");
  red_volt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_REDUCED |-> pwr.main_reg_volt == 2'h1 && pwr.main_reg_on)
    else $error("reduced voltage");
  sleep_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_sleep |-> pwr.ao_periph_en && pwr.battery_pins_en && !pwr.low_power_pins_en && !pwr.cpu_power_en)
    else $error("sleep resources");
  shut_cpu_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_SHUTDOWN |-> !pwr.cpu_power_en && !pwr.cpu_clock_en && !pwr.main_reg_on)
    else $error("shutdown supplies");
  gated_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_GATED |-> !pwr.cpu_clock_en && pwr.lp_periph_en && pwr.low_power_pins_en)
    else $error("gated resources");
  lowv_stby_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PSC_LOWV_STBY |-> !pwr.cpu_clock_en && pwr.cpu_power_en)
    else $error("low-voltage standby gating");
endmodule : psc_ctrl
